// *** hw/codec_device_end.sv ***
// Two-channel codec cascade: serial sequencing of control and data words
// Functional notes
// - Two output frame pulses per sample event
// - Host sends channel 2 word, then channel 1
// - Channel 1 framing feeds channel 2; both start together
// - Non-control words are forwarded unchanged
// - Nonzero address is decremented and forwarded
// - Addressed writes land in both channels together
// - Host sets divider 1, bit clock /2, rate /256
// - Host order: clocking, power, then mode register
// - Host powers ADCs, DACs and reference
// - Mode write with count field one enters data mode
// - Data mode: ADC results out, inputs are DAC words
// - Data mode counts frames; load DAC at count
// - Below count: raise framing, pass word on
// - DAC takes completing word; counter returns zero
// - ADC words leave channel 2 first
// - External input feeds channel 1, output from 2
// - Once started, host transmits whenever channel 2 frames
// - Host leaves no gap between control words
// - One read and write per channel every event
// - Reset into program mode, no conversion output
// - Device count field resets to zero
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
module codec_device_end #(
    parameter int CORE_DIV = 8
) (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    codec_link_if.device_end LINK_IO,
    input  wire logic [15:0] ADC_CH1_I,
    input  wire logic [15:0] ADC_CH2_I,
    output logic      [15:0] DAC_CH1_O,
    output logic      [15:0] DAC_CH2_O,
    output logic      [1:0]  DAC_UPDATE_O,
    output logic      [1:0]  DATA_MODE_O
);

    localparam int DIV_W = (CORE_DIV > 1) ? $clog2(CORE_DIV) : 1;

    typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_WAIT} slot_state_t;

    typedef struct packed {
        logic        fwd;
        logic [15:0] word;
        logic        wr;
        logic [2:0]  sel;
        logic [7:0]  data;
        logic        dac_ld;
        logic [3:0]  cnt;
    } verdict_t;

    // ****************************************
    // Word decision for one channel
    // ****************************************
    function automatic verdict_t judge(input logic [15:0] w, input logic [7:0] mode,
                                       input logic [3:0] cnt);
        verdict_t   v;
        logic [2:0] addr;
        v      = '0;
        v.word = w;
        v.cnt  = cnt;
        addr   = w[cc_pkg::ADDR_LSB +: cc_pkg::ADDR_W];
        if (mode[cc_pkg::MODE_DATA_BIT]) begin
            if (cnt == {1'b0, mode[cc_pkg::MODE_COUNT_LSB +: cc_pkg::COUNT_W]}) begin
                v.dac_ld = 1'b1;
                v.cnt    = '0;
            end else begin
                v.fwd = 1'b1;
                v.cnt = cnt + 4'h1;
            end
        end else if (w[cc_pkg::CTRL_BIT]) begin
            if (addr == cc_pkg::ADDR_SELF) begin
                v.wr   = 1'b1;
                v.sel  = w[cc_pkg::SEL_LSB +: cc_pkg::SEL_W];
                v.data = w[cc_pkg::DATA_W-1:0];
            end else begin
                v.fwd = 1'b1;
                v.word[cc_pkg::ADDR_LSB +: cc_pkg::ADDR_W] = addr - 3'h1;
            end
        end else begin
            v.fwd = 1'b1;
        end
        return v;
    endfunction : judge

    // ****************************************
    // Bit clock: divided core clock over two
    // ****************************************
    logic [DIV_W-1:0] dm_cnt;
    logic             sclk;
    logic [11:0]      evt_cnt;
    logic             evt_pending;
    logic [7:0]       mode_reg  [2];
    logic [7:0]       clk_reg   [2];
    logic [7:0]       pwr_reg   [2];
    logic [3:0]       cnt       [2];
    logic [15:0]      sreg      [2];
    logic [15:0]      dac_reg   [2];
    logic [1:0]       dac_upd;
    logic [1:0]       f;

    wire        dm_tick     = dm_cnt == DIV_W'(CORE_DIV - 1);
    wire        sclk_rise   = dm_tick && !sclk;
    wire        sclk_fall   = dm_tick && sclk;
    // Both channels hold the same clocking value, channel 2 drives timing
    wire [1:0]  rate        = clk_reg[1][cc_pkg::RATE_LSB +: cc_pkg::RATE_W];
    wire [11:0] frame_limit = cc_pkg::BASE_RATE_DIV << rate;
    wire        evt_tick    = dm_tick && (evt_cnt == frame_limit - 12'h001);

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            dm_cnt  <= '0;
            sclk    <= 1'b0;
            evt_cnt <= '0;
        end else begin
            dm_cnt <= dm_tick ? '0 : dm_cnt + DIV_W'(1);
            if (dm_tick) begin
                sclk    <= ~sclk;
                evt_cnt <= evt_tick ? 12'h000 : evt_cnt + 12'h001;
            end
        end
    end

    // ****************************************
    // Host word receiver on channel 1 input
    // ****************************************
    // Pins from the host pass two flops; the bit clock runs slow enough
    logic [1:0]  fs_sync;
    logic [1:0]  di_sync;
    logic [15:0] rx_sh;
    logic [3:0]  rx_idx;
    logic        rx_busy;
    logic        rx_got;

    wire rx_start = sclk_rise && !rx_busy && fs_sync[1];
    wire rx_done  = sclk_rise && rx_busy && rx_idx == cc_pkg::LAST_BIT;

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            fs_sync <= '0;
            di_sync <= '0;
            rx_sh   <= '0;
            rx_idx  <= '0;
            rx_busy <= 1'b0;
        end else begin
            fs_sync <= {fs_sync[0], LINK_IO.in_frame_pulse};
            di_sync <= {di_sync[0], LINK_IO.serial_in_line};
            if (rx_start || (sclk_rise && rx_busy)) begin
                rx_sh  <= {rx_sh[14:0], di_sync[1]};
                rx_idx <= rx_idx + 4'h1;
            end
            if (rx_start) begin
                rx_busy <= 1'b1;
            end else if (rx_done) begin
                rx_busy <= 1'b0;
            end
        end
    end

    // ****************************************
    // Slot sequencer
    // ****************************************
    slot_state_t state;
    logic [3:0]  bit_idx;
    logic        ofs;
    logic        dout;
    verdict_t    v [2];
    logic [1:0]  got;

    assign v[0]  = judge(rx_sh, mode_reg[0], cnt[0]);
    assign v[1]  = judge(sreg[0], mode_reg[1], cnt[1]);
    assign got   = {f[0], f[1] && rx_got};

    // No host word started means the host had nothing to send
    wire consume   = state == S_WAIT && (rx_got || !rx_busy);
    wire start_evt = state == S_IDLE && evt_pending;
    wire [1:0] next_f = {got[1] && v[1].fwd, got[0] && v[0].fwd};

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            evt_pending <= 1'b0;
            rx_got      <= 1'b0;
        end else begin
            evt_pending <= evt_tick || (evt_pending && !start_evt);
            rx_got      <= rx_done || (rx_got && !consume);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state   <= S_IDLE;
            f       <= '0;
            bit_idx <= '0;
        end else if (start_evt) begin
            state   <= S_SHIFT;
            f       <= 2'b11;
            bit_idx <= '0;
        end else if (state == S_SHIFT && sclk_fall) begin
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == cc_pkg::LAST_BIT) begin
                state <= S_WAIT;
            end
        end else if (consume) begin
            f       <= next_f;
            bit_idx <= '0;
            state   <= (next_f != 2'b00) ? S_SHIFT : S_IDLE;
        end
    end

    // Channel 2 shifts first; host sees its word ahead of channel 1's
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            ofs  <= 1'b0;
            dout <= 1'b0;
        end else if (sclk_fall) begin
            ofs  <= state == S_SHIFT && f[1] && bit_idx == '0;
            dout <= state == S_SHIFT && f[1] && sreg[1][cc_pkg::LAST_BIT - bit_idx];
        end
    end

    // ****************************************
    // Channel registers
    // ****************************************
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < 2; i++) begin
                mode_reg[i] <= cc_pkg::MODE_RESET;
                clk_reg[i]  <= cc_pkg::CLOCKING_RESET;
                pwr_reg[i]  <= cc_pkg::POWER_RESET;
                cnt[i]      <= '0;
                sreg[i]     <= '0;
                dac_reg[i]  <= '0;
            end
            dac_upd <= '0;
        end else begin
            dac_upd <= '0;
            for (int i = 0; i < 2; i++) begin
                if (start_evt) begin
                    sreg[i] <= '0;
                    if (mode_reg[i][cc_pkg::MODE_DATA_BIT] && pwr_reg[i][cc_pkg::PWR_ADC_BIT]
                        && pwr_reg[i][cc_pkg::PWR_REF_BIT]) begin
                        sreg[i] <= (i == 0) ? ADC_CH1_I : ADC_CH2_I;
                    end
                end else if (consume && got[i]) begin
                    cnt[i]  <= v[i].cnt;
                    sreg[i] <= v[i].word;
                    // Same cycle for both channels keeps clocking aligned
                    if (v[i].wr && v[i].sel == cc_pkg::SEL_MODE) begin
                        mode_reg[i] <= v[i].data;
                    end else if (v[i].wr && v[i].sel == cc_pkg::SEL_CLOCKING) begin
                        clk_reg[i] <= v[i].data;
                    end else if (v[i].wr && v[i].sel == cc_pkg::SEL_POWER) begin
                        pwr_reg[i] <= v[i].data;
                    end
                    // A powered-down DAC ignores its word
                    if (v[i].dac_ld && pwr_reg[i][cc_pkg::PWR_DAC_BIT]) begin
                        dac_reg[i] <= v[i].word;
                        dac_upd[i] <= 1'b1;
                    end
                end
            end
        end
    end

    assign LINK_IO.sclk            = sclk;
    assign LINK_IO.out_frame_pulse = ofs;
    assign LINK_IO.serial_out_line = dout;
    assign DAC_CH1_O    = dac_reg[0];
    assign DAC_CH2_O    = dac_reg[1];
    assign DAC_UPDATE_O = dac_upd;
    assign DATA_MODE_O  = {mode_reg[1][cc_pkg::MODE_DATA_BIT],
                           mode_reg[0][cc_pkg::MODE_DATA_BIT]};

endmodule : codec_device_end

// *** hw/cc_pkg.sv ***
// Shared constants for the cascaded codec serial link and its host end
package cc_pkg;

    // ****************************************
    // Word layout
    // ****************************************
    localparam int         WORD_W     = 16;
    localparam int         CTRL_BIT   = 15;
    localparam int         ADDR_LSB   = 11;
    localparam int         ADDR_W     = 3;
    localparam int         SEL_LSB    = 8;
    localparam int         SEL_W      = 3;
    localparam int         DATA_W     = 8;
    localparam logic [3:0] LAST_BIT   = 4'hf;
    localparam logic [2:0] ADDR_SELF  = 3'h0;
    localparam logic [2:0] ADDR_NEXT  = 3'h1;

    // ****************************************
    // Register selects and fields
    // ****************************************
    localparam logic [2:0] SEL_MODE     = 3'h0;
    localparam logic [2:0] SEL_CLOCKING = 3'h1;
    localparam logic [2:0] SEL_POWER    = 3'h2;

    localparam int         MODE_DATA_BIT  = 0;
    localparam int         MODE_COUNT_LSB = 4;
    localparam int         COUNT_W        = 3;
    localparam int         RATE_LSB       = 0;
    localparam int         RATE_W         = 2;
    localparam int         PWR_ADC_BIT    = 0;
    localparam int         PWR_DAC_BIT    = 1;
    localparam int         PWR_REF_BIT    = 2;

    localparam logic [7:0] MODE_RESET     = 8'h00;
    localparam logic [7:0] CLOCKING_RESET = 8'h00;
    localparam logic [7:0] POWER_RESET    = 8'h00;

    // Setup values: divider 1, bit clock over 2, rate over 256
    localparam logic [7:0] CLOCKING_SETUP = 8'h00;
    localparam logic [7:0] POWER_SETUP    = 8'h07;
    localparam logic [7:0] MODE_SETUP     = 8'h11;
    localparam logic [2:0] SETUP_LAST     = 3'h5;

    // Sample period in divided core clock ticks at rate code 0
    localparam logic [11:0] BASE_RATE_DIV = 12'h100;

    // ****************************************
    // Host command port map
    // ****************************************
    localparam int         HOST_ADDR_W    = 3;
    localparam logic [2:0] HOST_CTRL      = 3'h0;
    localparam logic [2:0] HOST_STAT      = 3'h1;
    localparam logic [2:0] HOST_DAC_CH1   = 3'h2;
    localparam logic [2:0] HOST_DAC_CH2   = 3'h3;
    localparam logic [2:0] HOST_ADC_CH1   = 3'h4;
    localparam logic [2:0] HOST_ADC_CH2   = 3'h5;
    localparam int         CTRL_START_BIT = 0;
    localparam int         STAT_RUN_BIT   = 0;
    localparam int         STAT_FRESH_BIT = 1;

endpackage : cc_pkg

// *** hw/codec_link_if.sv ***
// Serial link between the codec cascade and its host serial unit
`timescale 1ns/1ps
interface codec_link_if;
    logic sclk;
    logic in_frame_pulse;
    logic serial_in_line;
    logic out_frame_pulse;
    logic serial_out_line;

    modport device_end (
        output sclk,
        output out_frame_pulse,
        output serial_out_line,
        input  in_frame_pulse,
        input  serial_in_line
    );

    modport host_end (
        input  sclk,
        input  out_frame_pulse,
        input  serial_out_line,
        output in_frame_pulse,
        output serial_in_line
    );
endinterface : codec_link_if

// *** hw/codec_host_end.sv ***
// Host serial unit: automatic setup sequence then DAC/ADC word exchange
`timescale 1ns/1ps
module codec_host_end (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    codec_link_if.host_end   LINK_IO,
    input  wire logic [2:0]  ADDR_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [15:0] RDATA_O
);

    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_RUN} host_state_t;

    // ****************************************
    // Setup word table: pairs, channel 2 first
    // ****************************************
    function automatic logic [15:0] setup_word(input logic [2:0] k);
        logic [2:0] sel;
        logic [7:0] data;
        sel  = cc_pkg::SEL_CLOCKING;
        data = cc_pkg::CLOCKING_SETUP;
        if (k[2:1] == 2'h1) begin
            sel  = cc_pkg::SEL_POWER;
            data = cc_pkg::POWER_SETUP;
        end else if (k[2:1] == 2'h2) begin
            sel  = cc_pkg::SEL_MODE;
            data = cc_pkg::MODE_SETUP;
        end
        return {1'b1, 1'b0, k[0] ? cc_pkg::ADDR_SELF : cc_pkg::ADDR_NEXT, sel, data};
    endfunction : setup_word

    // ****************************************
    // Link sampling
    // ****************************************
    logic [2:0] sclk_sync;
    logic [1:0] fs_sync;
    logic [1:0] do_sync;

    wire rise = sclk_sync[1] && !sclk_sync[2];
    wire fall = !sclk_sync[1] && sclk_sync[2];

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            sclk_sync <= '0;
            fs_sync   <= '0;
            do_sync   <= '0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], LINK_IO.sclk};
            fs_sync   <= {fs_sync[0], LINK_IO.out_frame_pulse};
            do_sync   <= {do_sync[0], LINK_IO.serial_out_line};
        end
    end

    // ****************************************
    // Frame handling
    // ****************************************
    host_state_t state;
    logic [2:0]  k;
    logic        phase;
    logic        start_req;
    logic [15:0] dac [2];
    logic [15:0] adc [2];
    logic        fresh;
    logic [15:0] rx_sh;
    logic [3:0]  rx_idx;
    logic        rx_busy;
    logic        rx_phase;
    logic [15:0] tx_sh;
    logic [3:0]  tx_idx;
    logic        tx_arm;
    logic        tx_busy;
    logic        ifs;
    logic        din;

    wire frame   = rise && !rx_busy && fs_sync[1];
    wire rx_done = rise && rx_busy && rx_idx == cc_pkg::LAST_BIT;
    wire go      = frame && state == H_IDLE && start_req && !phase;
    wire send    = frame && (state != H_IDLE || go);
    wire [15:0] next_tx = (state == H_RUN) ? dac[~phase] : setup_word(k);
    wire wr_ctrl = WR_I && ADDR_I == cc_pkg::HOST_CTRL;
    wire rd_stat = RD_I && ADDR_I == cc_pkg::HOST_STAT;

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state     <= H_IDLE;
            k         <= '0;
            phase     <= 1'b0;
            start_req <= 1'b0;
        end else begin
            start_req <= wr_ctrl ? WDATA_I[cc_pkg::CTRL_START_BIT] : start_req;
            if (frame) begin
                phase <= ~phase;
            end
            if (go) begin
                state <= H_SETUP;
                k     <= 3'h1;
            end else if (frame && state == H_SETUP) begin
                k     <= k + 3'h1;
                state <= (k == cc_pkg::SETUP_LAST) ? H_RUN : H_SETUP;
            end
        end
    end

    // Receive: channel 2 word arrives first in each pair
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            rx_sh    <= '0;
            rx_idx   <= '0;
            rx_busy  <= 1'b0;
            rx_phase <= 1'b0;
            adc[0]   <= '0;
            adc[1]   <= '0;
            fresh    <= 1'b0;
        end else begin
            if (frame || (rise && rx_busy)) begin
                rx_sh  <= {rx_sh[14:0], do_sync[1]};
                rx_idx <= rx_idx + 4'h1;
            end
            if (frame) begin
                rx_busy  <= 1'b1;
                rx_phase <= phase;
            end else if (rx_done) begin
                rx_busy <= 1'b0;
                adc[~rx_phase] <= {rx_sh[14:0], do_sync[1]};
            end
            fresh <= (rx_done && rx_phase && state == H_RUN) || (fresh && !rd_stat);
        end
    end

    // Transmit starts on the very next falling bit clock: no gap
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            tx_sh   <= '0;
            tx_idx  <= '0;
            tx_arm  <= 1'b0;
            tx_busy <= 1'b0;
            ifs     <= 1'b0;
            din     <= 1'b0;
        end else begin
            if (send) begin
                tx_sh  <= next_tx;
                tx_arm <= 1'b1;
            end
            if (fall) begin
                ifs <= tx_arm;
                din <= (tx_arm || tx_busy) && tx_sh[cc_pkg::LAST_BIT - tx_idx];
                if (tx_arm) begin
                    tx_arm  <= 1'b0;
                    tx_busy <= 1'b1;
                    tx_idx  <= 4'h1;
                end else if (tx_busy) begin
                    tx_idx  <= tx_idx + 4'h1;
                    tx_busy <= tx_idx != cc_pkg::LAST_BIT;
                end
            end
        end
    end

    // ****************************************
    // Command port
    // ****************************************
    wire [15:0] stat_word = {14'h0000, fresh, state == H_RUN};

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            dac[0]  <= '0;
            dac[1]  <= '0;
            RDATA_O <= '0;
        end else begin
            if (WR_I && ADDR_I == cc_pkg::HOST_DAC_CH1) begin
                dac[0] <= WDATA_I;
            end else if (WR_I && ADDR_I == cc_pkg::HOST_DAC_CH2) begin
                dac[1] <= WDATA_I;
            end
            if (!RD_I) begin
                RDATA_O <= '0;
            end else if (ADDR_I == cc_pkg::HOST_STAT) begin
                RDATA_O <= stat_word;
            end else if (ADDR_I == cc_pkg::HOST_DAC_CH1) begin
                RDATA_O <= dac[0];
            end else if (ADDR_I == cc_pkg::HOST_DAC_CH2) begin
                RDATA_O <= dac[1];
            end else if (ADDR_I == cc_pkg::HOST_ADC_CH1) begin
                RDATA_O <= adc[0];
            end else if (ADDR_I == cc_pkg::HOST_ADC_CH2) begin
                RDATA_O <= adc[1];
            end else begin
                RDATA_O <= '0;
            end
        end
    end

    assign LINK_IO.in_frame_pulse = ifs;
    assign LINK_IO.serial_in_line = din;

endmodule : codec_host_end

// *** test/codec_link_assertions.sv ***
// Timing checks on the serial link between codec cascade and host unit
`timescale 1ns/1ps
module codec_link_assertions #(
    parameter int CORE_DIV = 8
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic sclk,
    input wire logic in_frame_pulse,
    input wire logic serial_in_line,
    input wire logic out_frame_pulse,
    input wire logic serial_out_line
);
    // ****************************************
    // Helper counters
    // ****************************************
    logic        sclk_q;
    logic        sclk_seen;
    logic [7:0]  half_cnt;
    logic [7:0]  out_len;
    logic [7:0]  in_len;
    logic [11:0] since_rise;
    wire         sclk_chg = sclk != sclk_q;
    wire         rise_now = out_frame_pulse && out_len == 8'h00;
    // Saturates so a long idle never wraps into a false short gap
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            sclk_q     <= 1'b0;
            sclk_seen  <= 1'b0;
            half_cnt   <= 8'h00;
            out_len    <= 8'h00;
            in_len     <= 8'h00;
            since_rise <= 12'hfff;
        end else begin
            sclk_q     <= sclk;
            sclk_seen  <= sclk_seen | sclk_chg;
            half_cnt   <= sclk_chg ? 8'h01 : half_cnt + 8'h01;
            out_len    <= out_frame_pulse ? out_len + 8'h01 : 8'h00;
            in_len     <= in_frame_pulse ? in_len + 8'h01 : 8'h00;
            since_rise <= rise_now ? 12'h001 : since_rise + {11'h000, ~&since_rise};
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    a_sclk_half_period: assert property (sclk_chg && sclk_seen |-> half_cnt == CORE_DIV)
        else $error("bit clock half period wrong");
    a_out_frame_width: assert property ($fell(out_frame_pulse) |-> out_len == 2 * CORE_DIV)
        else $error("output frame pulse not one bit long");
    a_out_frame_gap: assert property (rise_now |-> since_rise >= 32 * CORE_DIV)
        else $error("output frames closer than one word");
    a_frame_on_low: assert property ($changed(out_frame_pulse) |-> !sclk)
        else $error("output frame moved while bit clock high");
    a_out_data_low: assert property ($changed(serial_out_line) |-> !sclk)
        else $error("output data moved while bit clock high");
    a_in_frame_width: assert property ($fell(in_frame_pulse) |-> in_len == 2 * CORE_DIV)
        else $error("host frame pulse not one bit long");
    a_in_data_low: assert property ($changed(serial_in_line) |-> !sclk)
        else $error("host data moved while bit clock high");
    a_reset_quiet: assert property (disable iff (1'b0)
        RST_I |=> !sclk && !out_frame_pulse && !in_frame_pulse && !serial_out_line)
        else $error("link active during reset");
    c_out_frame: cover property (rise_now);
    c_in_frame: cover property ($rose(in_frame_pulse));
    c_out_data: cover property ($rose(serial_out_line));
endmodule : codec_link_assertions

// *** test/cascaded_codec_serial_sequencer_test.sv ***
// Self-checking bench: host setup sequence, data exchange and resets
`timescale 1ns/1ps
module cascaded_codec_serial_sequencer_test;
    typedef struct packed {logic [2:0] a; logic [15:0] w; logic [15:0] e;} row_t;
    localparam int   DIV = 8;
    localparam row_t ROWS [6] = '{'{cc_pkg::HOST_DAC_CH1, 16'h8000, 16'h8000},
        '{cc_pkg::HOST_DAC_CH2, 16'h7fff, 16'h7fff}, '{cc_pkg::HOST_STAT, 16'hffff, 16'h0000},
        '{cc_pkg::HOST_ADC_CH1, 16'h1234, 16'h0000}, '{3'h6, 16'hffff, 16'h0000},
        '{3'h7, 16'h0001, 16'h0000}};
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [2:0]  addr    = 3'h0;
    logic [15:0] wdata   = 16'h0000;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [15:0] rdata;
    logic [15:0] dac_ch1;
    logic [15:0] dac_ch2;
    logic [1:0]  dac_update;
    logic [1:0]  data_mode;
    logic [15:0] seen;
    int          num_errors = 0;
    int          n_tests    = 0;
    int          i;
    always #2.5 ref_clk = ~ref_clk;
    codec_link_if link ();
    codec_device_end #(.CORE_DIV(DIV)) u_codec_device_end (.REF_CLK_I(ref_clk), .RST_I(rst),
        .LINK_IO(link), .ADC_CH1_I(16'h1357), .ADC_CH2_I(16'h2468), .DAC_CH1_O(dac_ch1),
        .DAC_CH2_O(dac_ch2), .DAC_UPDATE_O(dac_update), .DATA_MODE_O(data_mode));
    codec_host_end u_codec_host_end (.REF_CLK_I(ref_clk), .RST_I(rst), .LINK_IO(link),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
    codec_link_assertions #(.CORE_DIV(DIV)) u_codec_link_assertions (.REF_CLK_I(ref_clk),
        .RST_I(rst), .sclk(link.sclk), .in_frame_pulse(link.in_frame_pulse),
        .serial_in_line(link.serial_in_line), .out_frame_pulse(link.out_frame_pulse),
        .serial_out_line(link.serial_out_line));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic limit(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            $display("ERROR wait bound %0d used up", lim);
            print_verdict();
        end
    endtask : limit
    task automatic bus_write(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask : bus_write
    // Read data stands only in the cycle after the strobe
    task automatic bus_read(input logic [2:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : bus_read
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("data mode", {14'h0, data_mode}, 16'h0000);
        check("dac ch1", dac_ch1, 16'h0000);
        for (i = 0; i < 6; i++) begin
            bus_write(ROWS[i].a, ROWS[i].w);
            bus_read(ROWS[i].a, seen);
            check("port row", seen, ROWS[i].e);
        end
        bus_write(cc_pkg::HOST_CTRL, 16'h0001);
        for (i = 0; i < 12000 && data_mode !== 2'b11; i++) begin
            @(posedge ref_clk);
            #1;
            if (dac_update !== 2'b00 || data_mode === 2'b01 || data_mode === 2'b10) begin
                check("early update or split mode", {12'h0, dac_update, data_mode}, 16'h0);
            end
        end
        limit(i, 12000);
        check("data mode", {14'h0, data_mode}, 16'h0003);
        for (i = 0; i < 6000 && dac_update !== 2'b11; i++) begin
            @(posedge ref_clk);
            #1;
        end
        limit(i, 6000);
        @(posedge ref_clk);
        #1;
        check("update pulse", {14'h0, dac_update}, 16'h0000);
        check("dac ch1", dac_ch1, 16'h8000);
        check("dac ch2", dac_ch2, 16'h7fff);
        bus_read(cc_pkg::HOST_STAT, seen);
        seen = 16'h0000;
        for (i = 0; i < 3000 && seen[cc_pkg::STAT_FRESH_BIT] !== 1'b1; i++) begin
            bus_read(cc_pkg::HOST_STAT, seen);
        end
        limit(i, 3000);
        check("running", {15'h0, seen[cc_pkg::STAT_RUN_BIT]}, 16'h0001);
        bus_read(cc_pkg::HOST_ADC_CH2, seen);
        check("adc ch2", seen, 16'h2468);
        bus_read(cc_pkg::HOST_ADC_CH1, seen);
        check("adc ch1", seen, 16'h1357);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        check("data mode", {14'h0, data_mode}, 16'h0000);
        check("dac ch2", dac_ch2, 16'h0000);
        @(posedge ref_clk);
        rst <= 1'b0;
        bus_read(cc_pkg::HOST_STAT, seen);
        check("status after reset", seen, 16'h0000);
        print_verdict();
    end
endmodule : cascaded_codec_serial_sequencer_test
